// ### design/gie_edge_sense.sv
`timescale 1ns/1ps
module gie_edge_sense
    import gie_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic pin_in,
    output logic rise_pulse,
    output logic fall_pulse
);
    // whole state of one pin sensor
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [1:0] fill;
        logic rise;
        logic fall;
    } gie_sense_t;

    gie_sense_t s;
    gie_sense_t next_s;

    // two-stage synchroniser, then compare consecutive samples
    always_comb begin
        next_s = s;
        next_s.sync1 = pin_in;
        next_s.sync2 = s.sync1;
        next_s.prev = s.sync2;
        if (s.fill != GIE_SENSE_FILL) begin
            next_s.fill = s.fill + 2'h1;
        end
        // no compare until prev holds a real sample, so a pin high at reset is no edge
        next_s.rise = (s.fill == GIE_SENSE_FILL) && s.sync2 && !s.prev;
        next_s.fall = (s.fill == GIE_SENSE_FILL) && !s.sync2 && s.prev;
    end

    // state register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rise_pulse = s.rise;
    assign fall_pulse = s.fall;
endmodule // gie_edge_sense

// ### design/gie_input_edge_detector.sv
// Notes on behaviour
// - upper control byte enables rising-edge detection per input port, 1 enables
// - lower control byte enables falling-edge detection per input port, 1 enables
// - in each byte, top bit serves port 7, lowest bit serves port 0
// - upper status byte flags ports where at least one rising edge occurred
// - lower status byte flags ports where at least one falling edge occurred
// - reading status returns flags then clears them, except a flag set by an edge counted in the read cycle; reset value zero
// - only ports with direction bit 0 (input) take part in detection
`timescale 1ns/1ps
module gie_input_edge_detector
    import gie_pkg::*;
#(
    parameter int unsigned NUM_PORTS = GIE_NUM_PORTS
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    // port pins and their direction setting from the port control register
    input wire logic [NUM_PORTS-1:0] port_pin,
    input wire logic [NUM_PORTS-1:0] port_is_output,
    // register port behind the serial transport
    input wire logic [GIE_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [GIE_DATA_W-1:0] reg_wdata,
    output logic [GIE_DATA_W-1:0] reg_rdata,
    output logic reg_ack,
    // live masks and flags, for neighbouring logic
    output logic [NUM_PORTS-1:0] rise_watch_mask,
    output logic [NUM_PORTS-1:0] fall_watch_mask,
    output logic [NUM_PORTS-1:0] rise_seen_flags,
    output logic [NUM_PORTS-1:0] fall_seen_flags
);
    // whole state of the block
    typedef struct packed {
        logic [NUM_PORTS-1:0] rise_watch_mask;
        logic [NUM_PORTS-1:0] fall_watch_mask;
        logic [NUM_PORTS-1:0] rise_seen_flags;
        logic [NUM_PORTS-1:0] fall_seen_flags;
        logic [GIE_DATA_W-1:0] rdata;
        logic ack;
    } gie_state_t;

    gie_state_t s;
    gie_state_t next_s;

    // raw one-cycle edge pulses from the pin sensors
    logic [NUM_PORTS-1:0] rise_pulse;
    logic [NUM_PORTS-1:0] fall_pulse;

    // pulses left after the polarity mask and the direction gate
    logic [NUM_PORTS-1:0] rise_hit;
    logic [NUM_PORTS-1:0] fall_hit;

    // address match of the two mapped registers
    logic hit_masks;
    logic hit_flags;

    // strobes qualified by the address match, plus any_access for any strobe
    logic wr_masks;
    logic rd_masks;
    logic rd_flags;
    logic any_access;

    // word a read in this cycle returns, taken from the state before the edge
    logic [GIE_DATA_W-1:0] read_word;

    // address compare, shared by the read and write paths
    function automatic logic gie_addr_is(input logic [GIE_ADDR_W-1:0] addr, input logic [7:0] ofs);
        gie_addr_is = (addr == ofs);
    endfunction

    // pack two port vectors into one 16-bit word, port i at bit i of each byte
    function automatic logic [GIE_DATA_W-1:0] gie_pack(input logic [7:0] hi, input logic [7:0] lo);
        logic [GIE_DATA_W-1:0] w;
        w = '0;
        w[GIE_RISE_LSB +: 8] = hi;
        w[GIE_FALL_LSB +: 8] = lo;
        gie_pack = w;
    endfunction

    // rising-edge half of a register word
    function automatic logic [7:0] gie_rise_field(input logic [GIE_DATA_W-1:0] w);
        gie_rise_field = w[GIE_RISE_LSB +: 8];
    endfunction

    // falling-edge half of a register word
    function automatic logic [7:0] gie_fall_field(input logic [GIE_DATA_W-1:0] w);
        gie_fall_field = w[GIE_FALL_LSB +: 8];
    endfunction

    // an edge counts only on an input port with its polarity watched
    function automatic logic gie_edge_counts(input logic pulse, input logic watch, input logic is_output);
        gie_edge_counts = pulse && watch && !is_output;
    endfunction

    // one synchroniser and edge sensor per pin
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_sense
            gie_edge_sense u_sense (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .pin_in(port_pin[gi]),
                .rise_pulse(rise_pulse[gi]),
                .fall_pulse(fall_pulse[gi])
            );

            // direction is checked when the edge is seen, not when the flag is read
            assign rise_hit[gi] = gie_edge_counts(rise_pulse[gi], s.rise_watch_mask[gi],
                port_is_output[gi]);
            assign fall_hit[gi] = gie_edge_counts(fall_pulse[gi], s.fall_watch_mask[gi],
                port_is_output[gi]);
        end
    endgenerate

    // decode of the two mapped registers
    assign hit_masks = gie_addr_is(reg_addr, GIE_OFS_WATCH_MASKS);
    assign hit_flags = gie_addr_is(reg_addr, GIE_OFS_SEEN_FLAGS);

    // qualified strobes and unqualified any_access; a write to the status register has no target and is dropped
    assign wr_masks = reg_wr && hit_masks;
    assign rd_masks = reg_rd && hit_masks;
    assign rd_flags = reg_rd && hit_flags;
    assign any_access = reg_rd || reg_wr;

    // read mux; unmapped addresses answer zero rather than a stale word
    assign read_word = rd_masks ? gie_pack(s.rise_watch_mask, s.fall_watch_mask) :
        rd_flags ? gie_pack(s.rise_seen_flags, s.fall_seen_flags) :
        GIE_UNMAPPED_RDATA;

    // next-state logic: register writes, reads, flag accumulation
    always_comb begin
        next_s = s;

        // every strobe cycle is answered one cycle later, writes included
        next_s.ack = any_access;

        // control register write: rising mask in upper byte, falling in lower
        if (wr_masks) begin
            next_s.rise_watch_mask = gie_rise_field(reg_wdata);
            next_s.fall_watch_mask = gie_fall_field(reg_wdata);
        end

        // read data holds until the next read, so a slow host still finds it
        if (reg_rd) begin
            next_s.rdata = read_word;
        end

        // clearing read drops the whole register, both halves at once
        if (rd_flags) begin
            next_s.rise_seen_flags = '0;
            next_s.fall_seen_flags = '0;
        end

        // set term last, so an edge landing on the clearing read survives it
        next_s.rise_seen_flags = next_s.rise_seen_flags | rise_hit;
        next_s.fall_seen_flags = next_s.fall_seen_flags | fall_hit;
    end

    // state register, all fields constant under reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s.rise_watch_mask <= GIE_WATCH_RESET;
            s.fall_watch_mask <= GIE_WATCH_RESET;
            s.rise_seen_flags <= GIE_SEEN_RESET;
            s.fall_seen_flags <= GIE_SEEN_RESET;
            s.rdata <= GIE_RDATA_RESET;
            s.ack <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // register port answer, straight from the state flops
    assign reg_rdata = s.rdata;
    assign reg_ack = s.ack;

    // live control masks
    assign rise_watch_mask = s.rise_watch_mask;
    assign fall_watch_mask = s.fall_watch_mask;

    // live sticky flags
    assign rise_seen_flags = s.rise_seen_flags;
    assign fall_seen_flags = s.fall_seen_flags;
endmodule // gie_input_edge_detector

// ### design/gie_pkg.sv
package gie_pkg;
    // port count and register data width
    localparam int unsigned GIE_NUM_PORTS = 8;
    localparam int unsigned GIE_ADDR_W = 8;
    localparam int unsigned GIE_DATA_W = 16;
    // register indices, as seen on the register port
    localparam logic [7:0] GIE_OFS_WATCH_MASKS = 8'h0d;
    localparam logic [7:0] GIE_OFS_SEEN_FLAGS = 8'h0e;
    // field positions: upper byte watches rising, lower byte falling
    localparam int unsigned GIE_RISE_LSB = 8;
    localparam int unsigned GIE_FALL_LSB = 0;
    // reset values
    localparam logic [7:0] GIE_WATCH_RESET = 8'h00;
    localparam logic [7:0] GIE_SEEN_RESET = 8'h00;
    localparam logic [15:0] GIE_RDATA_RESET = 16'h0000;
    localparam logic [15:0] GIE_UNMAPPED_RDATA = 16'h0000;
    // samples needed before an edge compare is trustworthy
    localparam logic [1:0] GIE_SENSE_FILL = 2'h3;
endpackage

// ### verification/gie_edge_monitor.sv
`timescale 1ns/1ps
// watches the register port and flag outputs of the edge detector
module gie_edge_monitor (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_ack,
    input wire logic [7:0] port_pin,
    input wire logic [7:0] port_is_output,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] rise_watch_mask,
    input wire logic [7:0] fall_watch_mask,
    input wire logic [7:0] rise_seen_flags,
    input wire logic [7:0] fall_seen_flags,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // decoded strobes; both flag bytes in register order
    logic st_rd, m_wr;
    logic [15:0] flags;
    assign st_rd = reg_rd && reg_addr == 8'h0e;
    assign m_wr = reg_wr && reg_addr == 8'h0d;
    assign flags = {rise_seen_flags, fall_seen_flags};
    chk_rise_mask: assert property (m_wr |=> rise_watch_mask == $past(reg_wdata[15:8]))
        else $error("rise mask not written");
    chk_fall_mask: assert property (m_wr |=> fall_watch_mask == $past(reg_wdata[7:0]))
        else $error("fall mask not written");
    chk_mask_hold: assert property (!m_wr |=> $stable(rise_watch_mask) && $stable(fall_watch_mask))
        else $error("mask changed");
    chk_read_data: assert property (st_rd |=> reg_ack && reg_rdata == $past(flags))
        else $error("status data wrong");
    chk_flags_sticky: assert property (!st_rd |=> (flags & $past(flags)) == $past(flags))
        else $error("flag lost");
    // quiet pins for four samples means nothing may survive the read
    chk_read_clears: assert property ($stable(port_pin)[*4] ##0 st_rd |=> flags == 16'h0000)
        else $error("flags not cleared");
    // direction as it stood in the cycle that set the flag
    chk_output_quiet: assert property ((flags & ~$past(flags) & {2{$past(port_is_output)}}) == 16'h0000)
        else $error("output port flagged");
    // a rise seen right after reset is lost by design, so it is left out
    chk_rise_delay: assert property ($rose(port_pin[7]) && $past(rstn)
        ##3 rise_watch_mask[7] && !port_is_output[7] |=> rise_seen_flags[7]) else $error("rise flag late");
endmodule // gie_edge_monitor
bind gie_input_edge_detector gie_edge_monitor u_mon (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_ack(reg_ack),
    .port_pin(port_pin),
    .port_is_output(port_is_output),
    .reg_addr(reg_addr),
    .rise_watch_mask(rise_watch_mask),
    .fall_watch_mask(fall_watch_mask),
    .rise_seen_flags(rise_seen_flags),
    .fall_seen_flags(fall_seen_flags),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
);

// ### verification/gie_host_model.sv
`timescale 1ns/1ps
// host side: one-cycle strobe, answer taken at the rising edge where ack stands high
module gie_host_model (
    input wire logic sys_clk,
    input wire logic reg_ack,
    input wire logic [15:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    // released bus shows the inverse, so stale values cannot pass
    task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [16:0] q);
        @(posedge sys_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {wr, !wr, a, d};
        @(posedge sys_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b00, ~a, ~d};
        // a longer strobe would repeat the clearing read and lose a fresh edge
        @(posedge sys_clk);
        q = {reg_ack, reg_rdata};
    endtask
endmodule // gie_host_model

// ### verification/gie_input_edge_detector_bench.sv
`timescale 1ns/1ps
module gie_input_edge_detector_bench;
    logic sys_clk = 1'b0, rstn = 1'b0, reg_wr, reg_rd, reg_ack;
    logic [7:0] port_pin = 8'h00, port_is_output = 8'h00, reg_addr;
    logic [7:0] rise_watch_mask, fall_watch_mask, rise_seen_flags, fall_seen_flags;
    logic [15:0] reg_wdata, reg_rdata;
    logic [16:0] q;
    int failures = 0, checked = 0;
    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;
    gie_input_edge_detector uut (.*);
    gie_host_model host (.*);
    task automatic tally_and_finish;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // the one compare: seen against expected, ack on top of the data
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // read, then compare ack and data together
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        host.access(1'b0, a, 16'h0000, q);
        check(q, {1'b1, e});
    endtask
    // write; only the ack is compared, read data keeps the last read
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.access(1'b1, a, d, q);
        check({16'h0000, q[16]}, 17'h00001);
    endtask
    // pins and direction move together; six cycles covers the four-cycle flag path
    task automatic pins(input logic [7:0] v, input logic [7:0] dir);
        @(posedge sys_clk);
        {port_pin, port_is_output} <= {v, dir};
        repeat (6) @(posedge sys_clk);
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(8'h0e, 16'h0000);
        // port 1 watched both ways, so only its direction keeps it out
        wr(8'h0d, 16'h8203);
        wr(8'h0e, 16'hffff);
        rd(8'h0d, 16'h8203);
        rd(8'h3f, 16'h0000);
        pins(8'h83, 8'h02);
        rd(8'h0e, 16'h8000);
        rd(8'h0e, 16'h0000);
        pins(8'h00, 8'h02);
        rd(8'h0e, 16'h0001);
        wr(8'h0d, 16'hffff);
        pins(8'h55, 8'h00);
        pins(8'haa, 8'h00);
        pins(8'h00, 8'h00);
        rd(8'h0e, 16'hffff);
        // rise whose flag lands on the clearing read edge: absent from that read, kept after it
        @(posedge sys_clk);
        port_pin <= 8'h80;
        repeat (2) @(posedge sys_clk);
        rd(8'h0e, 16'h0000);
        rd(8'h0e, 16'h8000);
        tally_and_finish;
    end
    // watchdog far beyond the 86 cycles the run needs
    initial begin
        repeat (3000) @(posedge sys_clk);
        failures++;
        tally_and_finish;
    end
endmodule // gie_input_edge_detector_bench
